// >>> hdl/aofc_top.sv
/*
  Output format configuration of a sampling converter: two mode registers
  reached over the serial port, and the output stage controls and data path
  they steer.
  Assumes the converted word arrives as a synchronous 14-bit offset binary
  value with a valid strobe, and that the pad ring obeys the enable outputs.
*/
// What this block does
// - The output-mode register sits at address 03h and the data-format register at 04h, 8 bits each.
// - Bits 1-0 of the output-mode register pick full-rate CMOS, DDR differential or DDR CMOS; 11 is unused.
// - Bits 6-4 of the output-mode register set the differential driver current from 1.75mA to 4.5mA.
// - Bit 3 turns on internal termination and scales the driver current by 1.6.
// - Bit 2 of the output-mode register drops data_oe and puts the data outputs in high impedance; sdo_oe does not follow it.
// - Bit 2 of the data-format register turns on alternate bit polarity on the output data.
// - Bit 1 of the data-format register turns on the output data randomizer.
// - Bit 0 of the data-format register selects offset binary when zero and two's complement when one.
// - Alternate polarity forces offset binary whatever the coding bit says.
// - Bit 7 of the output-mode register does nothing and writes to it are dropped.
// - A serial command writes the data to the addressed register when the flag is low and reads it back when high.
// - A software reset clears every mode register to 00h and its own bit clears itself.
`timescale 1ns/1ps
`include "aofc_defines.svh"

module aofc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire aofc_pkg::aofc_sample_type sample_in,
  output logic sdo_o,
  output logic sdo_oe,
  output aofc_pkg::aofc_config_type cfg,
  output logic [13:0] data_out,
  output logic data_valid,
  output logic data_oe,
  output logic [4:0] drive_current_ua_x100
);

  typedef struct packed {
    logic [7:0] out_drive;
    logic [7:0] data_fmt;
    logic soft_reset;
    logic [13:0] data;
    logic valid;
    logic oe;
    logic [4:0] cur;
    logic check_phase;
    logic sdo_oe;
  } aofc_top_state_type;

  aofc_top_state_type s_q;
  aofc_top_state_type s_d;
  logic [6:0] sp_addr;
  logic [7:0] sp_wr_data;
  logic sp_wr_stb;
  logic sp_sdo_oe;
  logic [7:0] rd_data;
  logic [13:0] word;

  // Current in units of 0.25mA; 1.75mA rounds to 7 (1.75/0.25 exact).
  function automatic logic [4:0] base_current(input logic [2:0] code);
    case (code)
      3'h0: base_current = 5'h0e;
      3'h1: base_current = 5'h10;
      3'h2: base_current = 5'h12;
      3'h4: base_current = 5'h0c;
      3'h5: base_current = 5'h0a;
      3'h6: base_current = 5'h08;
      3'h7: base_current = 5'h07;
      default: base_current = 5'h0e;
    endcase
  endfunction

  function automatic aofc_pkg::aofc_config_type decode(input logic [7:0] od, input logic [7:0] df);
    decode.output_format_select = aofc_pkg::aofc_format_type'(od[1:0]);
    decode.diff_drive_current = od[`AOFC_CUR_BIT_HI:`AOFC_CUR_BIT_LO];
    decode.internal_term_enable = od[`AOFC_TERM_BIT];
    decode.output_tristate = od[`AOFC_TRISTATE_BIT];
    decode.alternate_polarity_enable = df[`AOFC_ALTPOL_BIT];
    decode.data_scramble_enable = df[`AOFC_SCRAMBLE_BIT];
    decode.coding_select = df[`AOFC_CODING_BIT];
    decode.test_pattern_select = df[`AOFC_TEST_BIT_HI:`AOFC_TEST_BIT_LO];
  endfunction

  aofc_serial_port u_port (
    .clk(clk),
    .rst_n(rst_n),
    .sel_n(sel_n),
    .sclk(sclk),
    .sdi(sdi),
    .rd_data(rd_data),
    .addr(sp_addr),
    .wr_data(sp_wr_data),
    .wr_stb(sp_wr_stb),
    .sdo_oe(sp_sdo_oe)
  );

  always_comb begin
    aofc_pkg::aofc_config_type c;
    logic [5:0] scaled;
    c = decode(s_q.out_drive, s_q.data_fmt);
    scaled = 6'h00;
    word = sample_in.data;
    rd_data = 8'h00;
    s_d = s_q;
    s_d.sdo_oe = sp_sdo_oe;
    // Read back is combinational on the address so the port can shift it out.
    if (sp_addr == `AOFC_ADDR_OUT_DRIVE) begin
      rd_data = s_q.out_drive;
    end else if (sp_addr == `AOFC_ADDR_DATA_FMT) begin
      rd_data = s_q.data_fmt;
    end
    // A software reset takes one cycle; the bit is never stored as one for longer.
    s_d.soft_reset = 1'b0;
    if (s_q.soft_reset) begin
      s_d.out_drive = `AOFC_REG_RESET_VAL;
      s_d.data_fmt = `AOFC_REG_RESET_VAL;
    end else if (sp_wr_stb) begin
      if (sp_addr == `AOFC_ADDR_RESET) begin
        s_d.soft_reset = sp_wr_data[`AOFC_SOFT_RESET_BIT];
      end else if (sp_addr == `AOFC_ADDR_OUT_DRIVE) begin
        s_d.out_drive = sp_wr_data & `AOFC_OUT_DRIVE_MASK;
      end else if (sp_addr == `AOFC_ADDR_DATA_FMT) begin
        s_d.data_fmt = sp_wr_data & `AOFC_DATA_FMT_MASK;
      end
    end
    // Scaled by 1.6 as 8/5, truncated to quarter-milliamp steps.
    // The product is formed on ten bits because 18 times 8 would wrap on six.
    scaled = {1'b0, base_current(c.diff_drive_current)};
    if (c.internal_term_enable) begin
      s_d.cur = 5'(({4'h0, scaled} * 10'h008) / 10'h005);
    end else begin
      s_d.cur = scaled[4:0];
    end
    s_d.oe = ~c.output_tristate;
    if (!c.alternate_polarity_enable && c.coding_select) begin
      word = word ^ `AOFC_CODING_FLIP;
    end
    if (c.data_scramble_enable) begin
      word = word ^ ({14{word[0]}} & `AOFC_SCR_MASK);
    end
    if (c.alternate_polarity_enable) begin
      word = word ^ `AOFC_ALT_MASK;
    end
    if (sample_in.valid) begin
      s_d.check_phase = ~s_q.check_phase;
    end
    case (c.test_pattern_select)
      3'h1: word = `AOFC_PAT_ZERO;
      3'h3: word = `AOFC_PAT_ONE;
      3'h5: word = s_q.check_phase ? `AOFC_PAT_CHECK_B : `AOFC_PAT_CHECK_A;
      3'h7: word = s_q.check_phase ? `AOFC_PAT_ALT_B : `AOFC_PAT_ALT_A;
      default: word = word;
    endcase
    s_d.valid = sample_in.valid;
    if (sample_in.valid) begin
      s_d.data = word;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sdo_o = 1'b0;
  assign sdo_oe = s_q.sdo_oe;
  assign cfg = decode(s_q.out_drive, s_q.data_fmt);
  assign data_out = s_q.data;
  assign data_valid = s_q.valid;
  assign data_oe = s_q.oe;
  assign drive_current_ua_x100 = s_q.cur;

endmodule // aofc_top

// >>> hdl/aofc_defines.svh
/*
  Register offsets, field positions, reset values and fixed patterns for the
  converter output format configuration block.
  Assumes inclusion by bare name from design files of this block.
*/
`ifndef AOFC_DEFINES_SVH
`define AOFC_DEFINES_SVH

`define AOFC_ADDR_RESET 7'h00
`define AOFC_ADDR_OUT_DRIVE 7'h03
`define AOFC_ADDR_DATA_FMT 7'h04
`define AOFC_REG_RESET_VAL 8'h00
`define AOFC_SOFT_RESET_BIT 7
`define AOFC_FMT_BIT_LO 0
`define AOFC_FMT_BIT_HI 1
`define AOFC_TRISTATE_BIT 2
`define AOFC_TERM_BIT 3
`define AOFC_CUR_BIT_LO 4
`define AOFC_CUR_BIT_HI 6
`define AOFC_CODING_BIT 0
`define AOFC_SCRAMBLE_BIT 1
`define AOFC_ALTPOL_BIT 2
`define AOFC_TEST_BIT_LO 3
`define AOFC_TEST_BIT_HI 5
`define AOFC_OUT_DRIVE_MASK 8'h7f
`define AOFC_DATA_FMT_MASK 8'h3f
`define AOFC_CMD_BITS 16
`define AOFC_PAT_ZERO 14'h0000
`define AOFC_PAT_ONE 14'h3fff
`define AOFC_PAT_CHECK_A 14'h2aaa
`define AOFC_PAT_CHECK_B 14'h1555
`define AOFC_PAT_ALT_A 14'h0000
`define AOFC_PAT_ALT_B 14'h3fff
`define AOFC_SCR_MASK 14'h3ffe
`define AOFC_ALT_MASK 14'h2aaa
`define AOFC_CODING_FLIP 14'h2000

`endif

// >>> hdl/aofc_pkg.sv
/*
  Types shared by the output format configuration block.
  Assumes the defines header is compiled alongside.
*/
package aofc_pkg;

  typedef enum logic [1:0] {
    AOFC_FMT_CMOS = 2'b00,
    AOFC_FMT_DDR_DIFF = 2'b01,
    AOFC_FMT_DDR_CMOS = 2'b10,
    AOFC_FMT_UNUSED = 2'b11
  } aofc_format_type;

  typedef enum logic [1:0] {
    AOFC_ST_IDLE = 2'b00,
    AOFC_ST_SHIFT = 2'b01,
    AOFC_ST_READ = 2'b10
  } aofc_state_type;

  typedef struct packed {
    aofc_format_type output_format_select;
    logic [2:0] diff_drive_current;
    logic internal_term_enable;
    logic output_tristate;
    logic alternate_polarity_enable;
    logic data_scramble_enable;
    logic coding_select;
    logic [2:0] test_pattern_select;
  } aofc_config_type;

  typedef struct packed {
    logic [13:0] data;
    logic valid;
  } aofc_sample_type;

endpackage

// >>> hdl/aofc_serial_port.sv
/*
  Serial command port: a 16-bit frame of read flag, 7 address bits and 8 data
  bits, most significant first, sampled on the rising edge of the serial clock.
  Assumes all serial pins are synchronous to clk and sclk rises at most every
  other clk; the select is active low and frames each command.
*/
`timescale 1ns/1ps
`include "aofc_defines.svh"

module aofc_serial_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic [7:0] rd_data,
  output logic [6:0] addr,
  output logic [7:0] wr_data,
  output logic wr_stb,
  output logic sdo_oe
);

  typedef struct packed {
    aofc_pkg::aofc_state_type st;
    logic sclk_prev;
    logic [4:0] cnt;
    logic [15:0] sh;
    logic [7:0] rd_sh;
    logic [6:0] addr;
    logic [7:0] wr_data;
    logic wr_stb;
    logic sdo_oe;
  } aofc_sp_state_type;

  aofc_sp_state_type s_q;
  aofc_sp_state_type s_d;
  logic rise;

  always_comb begin
    s_d = s_q;
    s_d.wr_stb = 1'b0;
    s_d.sclk_prev = sclk;
    rise = sclk & ~s_q.sclk_prev;
    if (sel_n) begin
      s_d.st = aofc_pkg::AOFC_ST_IDLE;
      s_d.cnt = 5'h00;
      s_d.sdo_oe = 1'b0;
    end else begin
      case (s_q.st)
        aofc_pkg::AOFC_ST_IDLE: begin
          s_d.st = aofc_pkg::AOFC_ST_SHIFT;
          s_d.cnt = 5'h00;
        end
        aofc_pkg::AOFC_ST_SHIFT: begin
          if (rise) begin
            s_d.sh = {s_q.sh[14:0], sdi};
            s_d.cnt = s_q.cnt + 5'h01;
            if (s_q.cnt == 5'h07) begin
              // Read flag high: latch the register and shift it out, no write.
              if (s_q.sh[6]) begin
                s_d.addr = {s_q.sh[5:0], sdi};
                s_d.st = aofc_pkg::AOFC_ST_READ;
              end
            end
            if (s_q.cnt == 5'h0f) begin
              s_d.addr = s_q.sh[13:7];
              s_d.wr_data = {s_q.sh[6:0], sdi};
              s_d.wr_stb = 1'b1;
              s_d.st = aofc_pkg::AOFC_ST_IDLE;
            end
          end
        end
        aofc_pkg::AOFC_ST_READ: begin
          // Open drain: pull low for a zero bit, release for a one.
          if (s_q.cnt == 5'h08 && !s_q.sdo_oe && rise) begin
            s_d.rd_sh = {rd_data[6:0], 1'b0};
            s_d.sdo_oe = ~rd_data[7];
            s_d.cnt = s_q.cnt + 5'h01;
          end else if (s_q.cnt == 5'h08 && !rise) begin
            s_d.rd_sh = rd_data;
            s_d.sdo_oe = ~rd_data[7];
          end else if (rise && s_q.cnt < 5'h10) begin
            s_d.sdo_oe = ~s_q.rd_sh[7];
            s_d.rd_sh = {s_q.rd_sh[6:0], 1'b0};
            s_d.cnt = s_q.cnt + 5'h01;
          end else if (s_q.cnt >= 5'h10) begin
            s_d.sdo_oe = 1'b0;
          end
        end
        default: begin
          s_d.st = aofc_pkg::AOFC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign addr = s_q.addr;
  assign wr_data = s_q.wr_data;
  assign wr_stb = s_q.wr_stb;
  assign sdo_oe = s_q.sdo_oe;

endmodule // aofc_serial_port

// >>> tb/aofc_sva.sv
/* Concurrent checks on the output format block.
   Assumes it is bound to aofc_top and sees only that module's ports. */
`timescale 1ns/1ps
module aofc_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire aofc_pkg::aofc_sample_type sample_in,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire aofc_pkg::aofc_config_type cfg,
  input wire logic [13:0] data_out,
  input wire logic data_valid,
  input wire logic data_oe,
  input wire logic [4:0] drive_current_ua_x100
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic plain;
  logic [2:0] tp;
  assign plain = !(cfg.coding_select || cfg.alternate_polarity_enable || cfg.data_scramble_enable);
  assign tp = cfg.test_pattern_select;
  function automatic logic [4:0] cur_f(aofc_pkg::aofc_config_type c);
    logic [4:0] b;
    case (c.diff_drive_current)
      3'h1: b = 5'h10;
      3'h2: b = 5'h12;
      3'h4: b = 5'h0c;
      3'h5: b = 5'h0a;
      3'h6: b = 5'h08;
      3'h7: b = 5'h07;
      default: b = 5'h0e;
    endcase
    return c.internal_term_enable ? 5'((10'(b) * 10'h8) / 10'h5) : b;
  endfunction
  function automatic logic [13:0] fmt_f(logic [13:0] d, aofc_pkg::aofc_config_type c);
    logic [13:0] r;
    r = d;
    if (c.alternate_polarity_enable)
      r = r ^ 14'h2aaa;
    else if (c.coding_select)
      r = r ^ 14'h2000;
    if (c.data_scramble_enable)
      r = r ^ {{13{r[0]}}, 1'b0};
    return r;
  endfunction
  // A full frame and its write land well before the select has idled four cycles.
  sequence sel_idle_s;
    sel_n [*4];
  endsequence
  sequence sample_s;
    sample_in.valid && tp == 3'h0;
  endsequence
  sdo_idle_a: assert property (sel_n [*2] |-> !sdo_oe)
    else $error("sdo driven while deselected");
  cfg_quiet_a: assert property (sel_idle_s |-> $stable(cfg))
    else $error("config moved without a command");
  oe_follow_a: assert property (rst_n |=> data_oe == !$past(cfg.output_tristate))
    else $error("output enable does not follow tristate bit");
  cur_map_a: assert property (rst_n |=> drive_current_ua_x100 == cur_f($past(cfg)))
    else $error("drive current mismatch");
  data_map_a: assert property (sample_s |=> data_out == fmt_f($past(sample_in.data), $past(cfg)))
    else $error("formatted word mismatch");
  pat_zero_a: assert property (sample_in.valid && plain && tp == 3'h1 |=> data_out == 14'h0000)
    else $error("zero pattern mismatch");
  pat_one_a: assert property (sample_in.valid && plain && tp == 3'h3 |=> data_out == 14'h3fff)
    else $error("ones pattern mismatch");
  pat_alt_a: assert property (sample_in.valid && plain && tp == 3'h7
    |=> data_out == 14'h0000 || data_out == 14'h3fff)
    else $error("alternating pattern mismatch");
  valid_hold_a: assert property (!sample_in.valid |=> $stable(data_out) && !data_valid)
    else $error("output word moved without a sample");
endmodule // aofc_sva

bind aofc_top aofc_sva chk_u (.clk(clk), .rst_n(rst_n), .sel_n(sel_n), .sclk(sclk),
  .sdi(sdi), .sample_in(sample_in), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .cfg(cfg),
  .data_out(data_out), .data_valid(data_valid), .data_oe(data_oe),
  .drive_current_ua_x100(drive_current_ua_x100));

// >>> tb/aofc_host_model.sv
/* Serial host that frames 16-bit commands on the configuration port.
   Assumes sdo_line is the resolved open-drain level with its pull-up. */
`timescale 1ns/1ps
module aofc_host_model (
  input wire logic clk,
  input wire logic sdo_line,
  output logic sel_n,
  output logic sclk,
  output logic sdi
);
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  task automatic xfer(input logic [15:0] cmd, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk);
    sel_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk);
      sclk <= 1'b0;
      sdi <= cmd[i];
      @(posedge clk);
      sclk <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      // The port shows each read bit two clocks after the rise that shifts it.
      if (i <= 7)
        rd[i] = sdo_line;
      @(posedge clk);
    end
    @(posedge clk);
    sel_n <= 1'b1;
    // The data line is not pulled, so it must not keep the last bit.
    sdi <= ~sdi;
    repeat (4) @(posedge clk);
  endtask
endmodule // aofc_host_model

// >>> tb/test_aofc_top.sv
/* Self-checking bench for aofc_top.
   Assumes the host model owns the serial pins and this module the samples. */
`timescale 1ns/1ps
module test_aofc_top;
  logic clk, rst_n, sel_n, sclk, sdi, sdo_o, sdo_oe, data_valid, data_oe;
  aofc_pkg::aofc_sample_type sample_in;
  aofc_pkg::aofc_config_type cfg;
  logic [13:0] data_out, a;
  logic [4:0] cur;
  logic [7:0] rd;
  int bad_count, comparisons;
  wire sdo_line = sdo_oe ? sdo_o : 1'b1;
  localparam logic [13:0] D = 14'h0235;
  aofc_top dut_u (.clk(clk), .rst_n(rst_n), .sel_n(sel_n), .sclk(sclk), .sdi(sdi),
    .sample_in(sample_in), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .cfg(cfg), .data_out(data_out),
    .data_valid(data_valid), .data_oe(data_oe), .drive_current_ua_x100(cur));
  aofc_host_model host_u (.clk(clk), .sdo_line(sdo_line), .sel_n(sel_n), .sclk(sclk), .sdi(sdi));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] ad, input logic [7:0] d);
    host_u.xfer({1'b0, ad, d}, rd);
  endtask
  task automatic rdr(input logic [6:0] ad);
    host_u.xfer({1'b1, ad, 8'h00}, rd);
  endtask
  task automatic send(input logic [13:0] d);
    @(posedge clk);
    sample_in <= '{data: d, valid: 1'b1};
    @(posedge clk);
    sample_in.valid <= 1'b0;
    #1;
    chk(16'(data_valid), 16'h1);
    a = data_out;
  endtask
  task automatic t_regs;
    chk(16'(cfg), 16'h0);
    rdr(7'h03);
    chk(16'(rd), 16'h0);
    wr(7'h03, 8'hff);
    rdr(7'h03);
    chk(16'(rd), 16'h7f);
    chk(16'(data_oe), 16'h0);
    wr(7'h04, 8'hff);
    rdr(7'h04);
    chk(16'(rd), 16'h3f);
    rdr(7'h05);
    chk(16'(rd), 16'h0);
    $display("test regs done");
  endtask
  task automatic t_drive;
    logic [4:0] ex [8] = '{5'h0e, 5'h19, 5'h12, 5'h16, 5'h0c, 5'h10, 5'h08, 5'h0b};
    for (int i = 0; i < 8; i++) begin
      wr(7'h03, {1'b1, 3'(i), 1'(i), 1'b0, 2'(i % 3)});
      chk(16'(cfg.output_format_select), 16'(i % 3));
      chk(16'(cfg.diff_drive_current), 16'(i));
      chk(16'(cfg.internal_term_enable), 16'(i % 2));
      chk(16'(cur), 16'(ex[i]));
      chk(16'(data_oe), 16'h1);
    end
    $display("test drive done");
  endtask
  task automatic t_data;
    logic [7:0] fv [7] = '{8'h00, 8'h01, 8'h05, 8'h04, 8'h02, 8'h08, 8'h18};
    logic [13:0] ev [7] = '{D, D ^ 14'h2000, D ^ 14'h2aaa, D ^ 14'h2aaa, D ^ 14'h3ffe,
      14'h0000, 14'h3fff};
    logic [13:0] b;
    for (int i = 0; i < 7; i++) begin
      wr(7'h04, fv[i]);
      send(D);
      chk(16'(a), 16'(ev[i]));
    end
    for (int i = 0; i < 2; i++) begin
      wr(7'h04, i == 0 ? 8'h28 : 8'h38);
      send(D);
      b = a;
      send(D);
      chk(16'(a ^ b), 16'h3fff);
      chk(16'(a == 14'h2aaa || a == 14'h1555 || a == 14'h0000 || a == 14'h3fff), 16'h1);
    end
    $display("test data done");
  endtask
  task automatic t_reset;
    wr(7'h04, 8'h3f);
    wr(7'h00, 8'h80);
    chk(16'(cfg), 16'h0);
    rdr(7'h00);
    chk(16'(rd), 16'h0);
    wr(7'h03, 8'h7f);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(16'(cfg), 16'h0);
    $display("test reset done");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    sample_in = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_drive();
    t_data();
    t_reset();
    wrap_up();
  end
endmodule // test_aofc_top
